// file: verilog/pfl_pkg.sv
// pfl_pkg: constants and carrier types for the pin function and load control bank
package pfl_pkg;

  // ----------------------------------------------------------------
  // register port geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned PINS    = 8;
  localparam int unsigned CODE_W  = 12;
  localparam int unsigned CHAN_W  = 3;

  // ----------------------------------------------------------------
  // register offsets on the internal register port
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_ANALOG_OUT  = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_PULLDOWN    = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_LOAD_POLICY = 4'h7;

  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_ANALOG_OUT  = 16'h0000;
  localparam logic [DATA_W-1:0] RST_PULLDOWN    = 16'h00ff;
  localparam logic [DATA_W-1:0] RST_LOAD_POLICY = 16'h0000;
  localparam int unsigned       PIN_FIELD_MSB   = 7;
  localparam int unsigned       POLICY_MSB      = 1;

  // ----------------------------------------------------------------
  // load policy encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] LOAD_IMMEDIATE = 2'h0;
  localparam logic [1:0] LOAD_HOLD      = 2'h1;
  localparam logic [1:0] LOAD_BULK      = 2'h2;
  localparam logic [1:0] LOAD_UNDEF     = 2'h3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pfl_reg_req_t;

  typedef struct packed {
    logic              valid;
    logic [CHAN_W-1:0] chan;
    logic [CODE_W-1:0] data;
  } pfl_code_wr_t;

endpackage

// file: verilog/pfl_bank.sv
// pfl_bank: per-pin function selectors, pull-down selectors and converter load policy
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps

module pfl_bank (
  input  wire logic                                          clk,
  input  wire logic                                          rst_n,
  input  wire pfl_pkg::pfl_reg_req_t                         reg_req,
  input  wire logic                                          cfg_lock,
  input  wire pfl_pkg::pfl_code_wr_t                         code_wr,
  output logic [pfl_pkg::DATA_W-1:0]                         reg_rdata,
  output logic                                               reg_rvalid,
  output logic [pfl_pkg::PINS-1:0]                           pin_analog_out,
  output logic [pfl_pkg::PINS-1:0]                           pin_pulldown,
  output logic [1:0]                                         load_policy,
  output logic [pfl_pkg::PINS-1:0][pfl_pkg::CODE_W-1:0]      conv_code,
  output logic [pfl_pkg::PINS-1:0]                           conv_update
);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic                         wr_analog;
  logic                         wr_pulldown;
  logic                         wr_policy;
  logic                         bulk_load;
  logic                         immediate;

  assign wr_analog   = reg_req.wr && (reg_req.addr == pfl_pkg::ADDR_ANALOG_OUT);
  assign wr_pulldown = reg_req.wr && (reg_req.addr == pfl_pkg::ADDR_PULLDOWN);
  assign wr_policy   = reg_req.wr && (reg_req.addr == pfl_pkg::ADDR_LOAD_POLICY);
  // one event per write of the bulk code, never a level on the stored field
  assign bulk_load   = wr_policy
                       && (reg_req.wdata[pfl_pkg::POLICY_MSB:0] == pfl_pkg::LOAD_BULK);
  // undefined code falls back to immediate loading
  assign immediate   = (load_policy == pfl_pkg::LOAD_IMMEDIATE)
                       || (load_policy == pfl_pkg::LOAD_UNDEF);

  // ----------------------------------------------------------------
  // configuration registers and read path
  // ----------------------------------------------------------------
  logic [pfl_pkg::PINS-1:0]   next_pin_analog_out;
  logic [pfl_pkg::PINS-1:0]   next_pin_pulldown;
  logic [1:0]                 next_load_policy;
  logic [pfl_pkg::DATA_W-1:0] next_reg_rdata;
  logic                       next_reg_rvalid;

  always_comb begin
    next_pin_analog_out = pin_analog_out;
    next_pin_pulldown   = pin_pulldown;
    next_load_policy    = load_policy;
    // lock only guards the per-pin selectors; the load policy stays writable
    if (wr_analog && !cfg_lock) begin
      next_pin_analog_out = reg_req.wdata[pfl_pkg::PIN_FIELD_MSB:0];
    end
    if (wr_pulldown && !cfg_lock) begin
      next_pin_pulldown = reg_req.wdata[pfl_pkg::PIN_FIELD_MSB:0];
    end
    if (wr_policy) begin
      next_load_policy = reg_req.wdata[pfl_pkg::POLICY_MSB:0];
    end
    next_reg_rvalid = reg_req.rd;
    next_reg_rdata  = '0;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        pfl_pkg::ADDR_ANALOG_OUT: begin
          next_reg_rdata = {8'h00, pin_analog_out};
        end
        pfl_pkg::ADDR_PULLDOWN: begin
          next_reg_rdata = {8'h00, pin_pulldown};
        end
        pfl_pkg::ADDR_LOAD_POLICY: begin
          next_reg_rdata = {14'h0000, load_policy};
        end
        default: begin
          next_reg_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_analog_out <= pfl_pkg::RST_ANALOG_OUT[pfl_pkg::PIN_FIELD_MSB:0];
      pin_pulldown   <= pfl_pkg::RST_PULLDOWN[pfl_pkg::PIN_FIELD_MSB:0];
      load_policy    <= pfl_pkg::RST_LOAD_POLICY[pfl_pkg::POLICY_MSB:0];
      reg_rdata      <= '0;
      reg_rvalid     <= 1'b0;
    end else begin
      pin_analog_out <= next_pin_analog_out;
      pin_pulldown   <= next_pin_pulldown;
      load_policy    <= next_load_policy;
      reg_rdata      <= next_reg_rdata;
      reg_rvalid     <= next_reg_rvalid;
    end
  end

  // selectors leave the pin to the other configuration logic when zero;
  // this bank only claims a pin, it never decides a zero bit's function

  // ----------------------------------------------------------------
  // per-channel input and converter registers
  // ----------------------------------------------------------------
  logic [pfl_pkg::PINS-1:0][pfl_pkg::CODE_W-1:0] in_code;

  for (genvar ch = 0; ch < pfl_pkg::PINS; ch++) begin : g_chan
    logic                      hit;
    logic [pfl_pkg::CODE_W-1:0] next_in;
    logic [pfl_pkg::CODE_W-1:0] next_conv;
    logic                      next_upd;

    assign hit = code_wr.valid && (code_wr.chan == pfl_pkg::CHAN_W'(ch));

    always_comb begin
      next_in   = hit ? code_wr.data : in_code[ch];
      next_conv = conv_code[ch];
      next_upd  = 1'b0;
      // a same-cycle input write is folded into the bulk copy, so it is not lost
      if (bulk_load) begin
        next_conv = next_in;
        next_upd  = 1'b1;
      end else if (hit && immediate) begin
        next_conv = code_wr.data;
        next_upd  = 1'b1;
      end
      // hold and stored-bulk policies leave the converter register alone
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        in_code[ch]     <= '0;
        conv_code[ch]   <= '0;
        conv_update[ch] <= 1'b0;
      end else begin
        in_code[ch]     <= next_in;
        conv_code[ch]   <= next_conv;
        conv_update[ch] <= next_upd;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [pfl_pkg::ADDR_W-1:0] rd_addr_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_q <= '0;
    end else begin
      rd_addr_q <= reg_req.addr;
    end
  end

  a_analog_write_takes: assert property (
    wr_analog && !cfg_lock |=> pin_analog_out == $past(reg_req.wdata[7:0]))
    else $error("analog selector write not stored");

  a_lock_blocks_write: assert property (
    (wr_analog || wr_pulldown) && cfg_lock |=> $stable(pin_analog_out) && $stable(pin_pulldown))
    else $error("locked selector changed");

  a_analog_upper_zero: assert property (
    reg_rvalid && rd_addr_q == pfl_pkg::ADDR_ANALOG_OUT
    |-> reg_rdata == {8'h00, $past(pin_analog_out)})
    else $error("analog selector readback wrong");

  a_pulldown_write_takes: assert property (
    wr_pulldown && !cfg_lock |=> pin_pulldown == $past(reg_req.wdata[7:0]))
    else $error("pull-down selector write not stored");

  a_policy_upper_zero: assert property (
    reg_rvalid && rd_addr_q == pfl_pkg::ADDR_LOAD_POLICY
    |-> reg_rdata[15:2] == 14'h0000 && reg_rdata[1:0] == $past(load_policy))
    else $error("load policy readback wrong");

  a_immediate_load: assert property (
    code_wr.valid && load_policy == pfl_pkg::LOAD_IMMEDIATE && !bulk_load
    |=> conv_update[$past(code_wr.chan)] && conv_code[$past(code_wr.chan)] == $past(code_wr.data))
    else $error("immediate load missed");

  a_hold_no_update: assert property (
    code_wr.valid && load_policy == pfl_pkg::LOAD_HOLD && !bulk_load
    |=> conv_update == 8'h00 && $stable(conv_code))
    else $error("converter changed in hold policy");

  a_bulk_all_update: assert property (
    bulk_load |=> conv_update == 8'hff ##1 conv_update == 8'h00 || $past(bulk_load))
    else $error("bulk copy did not update all channels together");

  a_undef_as_immediate: assert property (
    code_wr.valid && load_policy == pfl_pkg::LOAD_UNDEF && !bulk_load
    |=> conv_update[$past(code_wr.chan)])
    else $error("undefined policy did not load immediately");

  a_bulk_one_shot: assert property (
    code_wr.valid && load_policy == pfl_pkg::LOAD_BULK && !bulk_load
    |=> conv_update == 8'h00)
    else $error("stored bulk policy repeated the copy");

  // ----------------------------------------------------------------
  // read path, write path and converter checks
  // ----------------------------------------------------------------

  a_pulldown_readback: assert property (
    reg_rvalid && rd_addr_q == pfl_pkg::ADDR_PULLDOWN
    |-> reg_rdata == {8'h00, $past(pin_pulldown)})
    else $error("pull-down selector readback wrong");

  a_unmapped_reads_zero: assert property (
    reg_rvalid && rd_addr_q != pfl_pkg::ADDR_ANALOG_OUT && rd_addr_q != pfl_pkg::ADDR_PULLDOWN
    && rd_addr_q != pfl_pkg::ADDR_LOAD_POLICY |-> reg_rdata == 16'h0000)
    else $error("unmapped read returned data");

  a_read_answers: assert property (
    reg_req.rd
    |=> reg_rvalid)
    else $error("read not answered");

  a_idle_read_quiet: assert property (
    !reg_req.rd
    |=> !reg_rvalid && reg_rdata == 16'h0000)
    else $error("read data shown without a read");

  a_analog_no_stray: assert property (
    !wr_analog || cfg_lock
    |=> $stable(pin_analog_out))
    else $error("analog selector changed without a write");

  a_pulldown_no_stray: assert property (
    !wr_pulldown || cfg_lock
    |=> $stable(pin_pulldown))
    else $error("pull-down selector changed without a write");

  a_pulldown_lock_holds: assert property (
    wr_pulldown && cfg_lock
    |=> $stable(pin_pulldown))
    else $error("locked pull-down selector changed");

  a_policy_write_takes: assert property (
    wr_policy
    |=> load_policy == $past(reg_req.wdata[1:0]))
    else $error("load policy write not stored");

  a_policy_no_stray: assert property (
    !wr_policy
    |=> $stable(load_policy))
    else $error("load policy changed without a write");

  a_policy_lock_free: assert property (
    wr_policy && cfg_lock
    |=> load_policy == $past(reg_req.wdata[1:0]))
    else $error("lock blocked a load policy write");

  a_undef_policy_kept: assert property (
    wr_policy && reg_req.wdata[1:0] == pfl_pkg::LOAD_UNDEF
    |=> load_policy == pfl_pkg::LOAD_UNDEF)
    else $error("undefined policy not stored");

  a_input_always_stored: assert property (
    code_wr.valid
    |=> in_code[$past(code_wr.chan)] == $past(code_wr.data))
    else $error("input register write lost");

  a_converter_idle: assert property (
    !bulk_load && !code_wr.valid
    |=> $stable(conv_code) && conv_update == 8'h00)
    else $error("converter changed with no cause");

  a_bulk_copies_inputs: assert property (
    bulk_load
    |=> conv_code == in_code)
    else $error("bulk copy did not match input registers");

  a_immediate_one_channel: assert property (
    code_wr.valid && immediate && !bulk_load
    |=> (conv_update & ~(8'h01 << $past(code_wr.chan))) == 8'h00)
    else $error("immediate load touched another channel");

  a_update_onehot: assert property (
    conv_update != 8'hff
    |-> $onehot0(conv_update))
    else $error("partial multi-channel update");

  a_update_has_cause: assert property (
    conv_update != 8'h00
    |-> $past(bulk_load) || $past(code_wr.valid))
    else $error("converter update with no write");

  a_full_update_cause: assert property (
    conv_update == 8'hff
    |-> $past(bulk_load))
    else $error("all channels updated without a bulk write");

endmodule

// file: tb/test_pin_function_and_load_control.sv
// test_pin_function_and_load_control: self-checking bench for the pfl_bank register block
`timescale 1ns/1ps

module test_pin_function_and_load_control;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                                          clk;
  logic                                          rst_n;
  pfl_pkg::pfl_reg_req_t                         reg_req;
  logic                                          cfg_lock;
  pfl_pkg::pfl_code_wr_t                         code_wr;
  logic [pfl_pkg::DATA_W-1:0]                    reg_rdata;
  logic                                          reg_rvalid;
  logic [pfl_pkg::PINS-1:0]                      pin_analog_out;
  logic [pfl_pkg::PINS-1:0]                      pin_pulldown;
  logic [1:0]                                    load_policy;
  logic [pfl_pkg::PINS-1:0][pfl_pkg::CODE_W-1:0] conv_code;
  logic [pfl_pkg::PINS-1:0]                      conv_update;
  int                                            error_cnt;
  int                                            cmp_count;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rexp;
  } pfl_row_t;

  // reserved bits are written as ones so a missing mask shows up on readback
  pfl_row_t rows [5] = '{
    '{4'h5, 16'hffa5, 16'h00a5},
    '{4'h6, 16'hff34, 16'h0034},
    '{4'h7, 16'hfffd, 16'h0001},
    '{4'h7, 16'hfff0, 16'h0000},
    '{4'h3, 16'hffff, 16'h0000}
  };

  pfl_bank i_pfl_bank (
    .clk            (clk),
    .rst_n          (rst_n),
    .reg_req        (reg_req),
    .cfg_lock       (cfg_lock),
    .code_wr        (code_wr),
    .reg_rdata      (reg_rdata),
    .reg_rvalid     (reg_rvalid),
    .pin_analog_out (pin_analog_out),
    .pin_pulldown   (pin_pulldown),
    .load_policy    (load_policy),
    .conv_code      (conv_code),
    .conv_update    (conv_update)
  );

  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle strobe; returns just after the taking edge has landed
  task automatic req(input logic wr, input logic rd, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_req <= '{wr: wr, rd: rd, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
    #1;
  endtask

  task automatic cw(input logic [2:0] ch, input logic [11:0] d);
    @(posedge clk);
    code_wr <= '{valid: 1'b1, chan: ch, data: d};
    @(posedge clk);
    code_wr <= '0;
    #1;
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    #1000000;
    error_cnt++;
    close_out();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_req = '0;
    cfg_lock = 1'b0;
    code_wr = '0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    #1;
    chk(16'(pin_analog_out), 16'h0000);
    chk(16'(pin_pulldown), 16'h00ff);
    chk(16'(load_policy), 16'h0000);
    @(posedge clk);
    rst_n <= 1'b1;
    req(1'b0, 1'b1, 4'h6, 16'h0000);
    chk(reg_rdata, 16'h00ff);
    for (int i = 0; i < 5; i++) begin
      req(1'b1, 1'b0, rows[i].addr, rows[i].wdata);
      req(1'b0, 1'b1, rows[i].addr, 16'h0000);
      chk(16'(reg_rvalid), 16'h0001);
      chk(reg_rdata, rows[i].rexp);
    end
    chk(16'(pin_analog_out), 16'h00a5);
    chk(16'(pin_pulldown), 16'h0034);
    // write and read together: the read sees the old contents
    req(1'b1, 1'b1, 4'h5, 16'h005a);
    chk(reg_rdata, 16'h00a5);
    chk(16'(pin_analog_out), 16'h005a);
    chk(16'(pin_analog_out & 8'ha5), 16'h0000);
    @(posedge clk);
    cfg_lock <= 1'b1;
    req(1'b1, 1'b0, 4'h5, 16'h00ff);
    req(1'b1, 1'b0, 4'h6, 16'h0000);
    chk(16'(pin_analog_out), 16'h005a);
    chk(16'(pin_pulldown), 16'h0034);
    @(posedge clk);
    cfg_lock <= 1'b0;
    cw(3'h3, 12'habc);
    chk(16'(conv_code[3]), 16'h0abc);
    chk(16'(conv_update), 16'h0008);
    @(posedge clk);
    #1;
    chk(16'(conv_update), 16'h0000);
    req(1'b1, 1'b0, 4'h7, 16'h0001);
    cw(3'h2, 12'h555);
    chk(16'(conv_update), 16'h0000);
    chk(16'(conv_code[2]), 16'h0000);
    req(1'b1, 1'b0, 4'h7, 16'h0002);
    chk(16'(conv_update), 16'h00ff);
    chk(16'(conv_code[2]), 16'h0555);
    chk(16'(conv_code[3]), 16'h0abc);
    chk(16'(load_policy), 16'h0002);
    cw(3'h5, 12'h111);
    chk(16'(conv_update), 16'h0000);
    chk(16'(conv_code[5]), 16'h0000);
    req(1'b1, 1'b0, 4'h7, 16'h0003);
    chk(16'(load_policy), 16'h0003);
    cw(3'h5, 12'h222);
    chk(16'(conv_update), 16'h0020);
    chk(16'(conv_code[5]), 16'h0222);
    close_out();
  end
endmodule
